//--- core/edw_pkg.sv
// Constants shared by the extended data page window and its target decoder.
// Assumes a 16-bit data address space with a 15-bit page offset.
package edw_pkg;
    localparam int DATA_ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int OFFSET_W = 15;
    localparam int READ_PAGE_W = 10;
    localparam int WRITE_PAGE_W = 9;
    localparam int EXT_ADDR_W = READ_PAGE_W + OFFSET_W;
    localparam int WINDOW_BIT = 15;
    localparam int PROG_PAGE_BIT = 9;
    localparam logic [READ_PAGE_W-1:0] BASE_PAGE = 10'h000;
    localparam logic [DATA_ADDR_W-1:0] BASE_DATA_LO = 16'h0800;
    localparam logic [DATA_ADDR_W-1:0] BASE_DATA_HI = 16'h7FFF;
    localparam logic [READ_PAGE_W-1:0] READ_PAGE_RESET = 10'h001;
    localparam logic [WRITE_PAGE_W-1:0] WRITE_PAGE_RESET = 9'h001;
    localparam logic [READ_PAGE_W-1:0] RAM_LAST_PAGE_DEFAULT = 10'h001;
endpackage : edw_pkg

//--- core/edw_target_decode.sv
// Sorts a non-zero extended page into on-chip RAM, parallel port or program space.
// Assumes the caller never presents page zero as an extended access.
`timescale 1ns/1ps
module edw_target_decode #(
    parameter logic [edw_pkg::READ_PAGE_W-1:0] RAM_LAST_PAGE = edw_pkg::RAM_LAST_PAGE_DEFAULT
) (
    edw_target_if.decoder tgt // Page in, target kind out.
);
    // Program space is only ever read; the narrower write page cannot reach it.
    wire progPage = tgt.page[edw_pkg::PROG_PAGE_BIT] & ~tgt.isWrite;
    wire ramPage = ~progPage & (tgt.page <= RAM_LAST_PAGE);
    assign tgt.hitProg = progPage;
    assign tgt.hitRam = ramPage;
    assign tgt.hitPort = ~progPage & ~ramPage;
endmodule : edw_target_decode

//--- core/edw_target_if.sv
// Carrier between the window logic and the extended target decoder.
// Assumes both ends sit in the same clock domain; the decode is combinational.
`timescale 1ns/1ps
interface edw_target_if;
    logic [edw_pkg::READ_PAGE_W-1:0] page;
    logic isWrite;
    logic hitRam;
    logic hitPort;
    logic hitProg;
    modport decoder (input page, input isWrite, output hitRam, output hitPort, output hitProg);
    modport user (output page, output isWrite, input hitRam, input hitPort, input hitProg);
endinterface : edw_target_if

//--- core/edw_window.sv
// Extended data page window: maps the upper half of data space onto a selected page.
// Assumes the core presents one access per cycle on core_clk and takes results a cycle later.
//
// Overview of operation
// - Extended memory reached only through upper half.
// - Extended space split into 32 Kbyte pages.
// - Reads use the 10-bit read page.
// - Writes use the separate 9-bit write page.
// - Page zero in window raises address trap.
// - Page zero is base data, reached directly.
// - Targets: extended RAM, parallel port, program space.
`timescale 1ns/1ps
module edw_window #(
    parameter logic [edw_pkg::READ_PAGE_W-1:0] RAM_LAST_PAGE = edw_pkg::RAM_LAST_PAGE_DEFAULT
) (
    input wire logic core_clk, // System clock, 125 MHz.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic readPageLoad, // Pulse: load the read page select.
    input wire logic [edw_pkg::READ_PAGE_W-1:0] readPageValue, // New read page.
    input wire logic writePageLoad, // Pulse: load the write page select.
    input wire logic [edw_pkg::WRITE_PAGE_W-1:0] writePageValue, // New write page.
    input wire logic accReq, // Pulse: core data access this cycle.
    input wire logic accWrite, // High for a write access.
    input wire logic [edw_pkg::DATA_ADDR_W-1:0] accAddr, // Core data address.
    input wire logic [edw_pkg::DATA_W-1:0] accWdata, // Core write data.
    output logic [edw_pkg::READ_PAGE_W-1:0] dataReadPageSelect, // Current read page.
    output logic [edw_pkg::WRITE_PAGE_W-1:0] dataWritePageSelect, // Current write page.
    output logic baseReq, // Pulse: direct access to lower data space.
    output logic [edw_pkg::DATA_ADDR_W-1:0] baseAddr, // Lower data space address.
    output logic extReq, // Pulse: access through the window.
    output logic extWrite, // Direction of the forwarded access.
    output logic [edw_pkg::EXT_ADDR_W-1:0] extAddr, // Extended data space address.
    output logic [edw_pkg::DATA_W-1:0] fwdWdata, // Write data for either path.
    output logic tgtRam, // Extended access goes to on-chip extended RAM.
    output logic tgtPort, // Extended access goes to the parallel memory port.
    output logic tgtProg, // Extended access goes to program space visibility.
    output logic addrErrTrap // Pulse: window access to page zero.
);
    edw_target_if tgt ();

    wire inWindow = accAddr[edw_pkg::WINDOW_BIT];
    wire [edw_pkg::READ_PAGE_W-1:0] selPage = accWrite ? {1'b0, dataWritePageSelect}
                                                       : dataReadPageSelect;
    wire pageZero = (selPage == edw_pkg::BASE_PAGE);
    wire goBase = accReq & ~inWindow;
    wire goExt = accReq & inWindow & ~pageZero;
    wire goTrap = accReq & inWindow & pageZero;
    // One page of offset per window: the page number is the only upper part.
    wire [edw_pkg::EXT_ADDR_W-1:0] next_extAddr = {selPage, accAddr[edw_pkg::OFFSET_W-1:0]};

    assign tgt.page = selPage;
    assign tgt.isWrite = accWrite;

    edw_target_decode #(
        .RAM_LAST_PAGE(RAM_LAST_PAGE)
    ) u_decode (
        .tgt(tgt.decoder)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dataReadPageSelect <= edw_pkg::READ_PAGE_RESET;
            dataWritePageSelect <= edw_pkg::WRITE_PAGE_RESET;
        end else begin
            if (readPageLoad) begin
                dataReadPageSelect <= readPageValue;
            end
            if (writePageLoad) begin
                dataWritePageSelect <= writePageValue;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            baseReq <= 1'b0;
            extReq <= 1'b0;
            addrErrTrap <= 1'b0;
            extWrite <= 1'b0;
            baseAddr <= 16'h0000;
            extAddr <= '0;
            fwdWdata <= 16'h0000;
            tgtRam <= 1'b0;
            tgtPort <= 1'b0;
            tgtProg <= 1'b0;
        end else begin
            baseReq <= goBase;
            extReq <= goExt;
            addrErrTrap <= goTrap;
            extWrite <= accWrite;
            baseAddr <= accAddr;
            extAddr <= next_extAddr;
            fwdWdata <= accWdata;
            tgtRam <= goExt & tgt.hitRam;
            tgtPort <= goExt & tgt.hitPort;
            tgtProg <= goExt & tgt.hitProg;
        end
    end

    // Address and data copies follow the core on every edge; only the strobes say which copy is live.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_low_half_direct;
        accReq && !accAddr[15] |=> baseReq && !extReq && !addrErrTrap && baseAddr == $past(accAddr);
    endproperty
    a_low_half_direct: assert property (p_low_half_direct) else $error("Lower half access left the base path.");

    property p_page_offset;
        extReq |-> extAddr[14:0] == $past(accAddr[14:0]) && $past(accAddr[15]);
    endproperty
    a_page_offset: assert property (p_page_offset) else $error("Window offset not kept within one page.");

    property p_read_page;
        accReq && !accWrite && accAddr[15] && dataReadPageSelect != 10'h000
            |=> extReq && extAddr[24:15] == $past(dataReadPageSelect);
    endproperty
    a_read_page: assert property (p_read_page) else $error("Read did not use the read page.");

    property p_write_page;
        accReq && accWrite && accAddr[15] && dataWritePageSelect != 9'h000
            |=> extReq && extWrite && extAddr[24:15] == {1'b0, $past(dataWritePageSelect)};
    endproperty
    a_write_page: assert property (p_write_page) else $error("Write did not use the write page.");

    property p_page_zero_trap;
        accReq && accAddr[15] && (accWrite ? dataWritePageSelect == 9'h000 : dataReadPageSelect == 10'h000)
            |=> addrErrTrap && !extReq && !baseReq ##1 !addrErrTrap || accReq;
    endproperty
    a_page_zero_trap: assert property (p_page_zero_trap) else $error("Page zero window access gave no trap.");

    property p_trap_only_window;
        addrErrTrap |-> $past(accReq) && $past(accAddr[15]) && !tgtRam && !tgtPort && !tgtProg;
    endproperty
    a_trap_only_window: assert property (p_trap_only_window) else $error("Trap raised without a window access.");

    property p_one_target;
        extReq |-> $onehot({tgtRam, tgtPort, tgtProg}) && !(extWrite && tgtProg);
    endproperty
    a_one_target: assert property (p_one_target) else $error("Extended access lacks a single target.");

    property p_no_stray_target;
        !extReq |-> !tgtRam && !tgtPort && !tgtProg;
    endproperty
    a_no_stray_target: assert property (p_no_stray_target) else $error("Target flag without an access.");

    property p_page_load;
        readPageLoad && !writePageLoad |=> dataReadPageSelect == $past(readPageValue)
            && $stable(dataWritePageSelect);
    endproperty
    a_page_load: assert property (p_page_load) else $error("Read page load disturbed the selectors.");

    // Exactly one answer per access, so a trap can never hide behind a forwarded request.
    property p_one_answer;
        accReq |=> $onehot({baseReq, extReq, addrErrTrap});
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("Access gave other than one answer.");

    property p_quiet_idle;
        !accReq |=> !baseReq && !extReq && !addrErrTrap;
    endproperty
    a_quiet_idle: assert property (p_quiet_idle) else $error("Request pulse without an access.");

    property p_ext_from_window;
        extReq |-> $past(accReq) && $past(accAddr[edw_pkg::WINDOW_BIT]) && !baseReq;
    endproperty
    a_ext_from_window: assert property (p_ext_from_window) else $error("Extended access from lower half.");

    property p_base_range;
        accReq && accAddr >= edw_pkg::BASE_DATA_LO && accAddr <= edw_pkg::BASE_DATA_HI
            |=> baseReq && !addrErrTrap && baseAddr == $past(accAddr);
    endproperty
    a_base_range: assert property (p_base_range) else $error("Base data access not taken directly.");

    property p_trap_page_zero;
        addrErrTrap |-> ($past(accWrite) && $past(dataWritePageSelect) == 9'h000)
            || (!$past(accWrite) && $past(dataReadPageSelect) == 10'h000);
    endproperty
    a_trap_page_zero: assert property (p_trap_page_zero) else $error("Trap raised for a non-zero page.");

    property p_ext_page_nonzero;
        extReq |-> extAddr[24:15] != 10'h000;
    endproperty
    a_ext_page_nonzero: assert property (p_ext_page_nonzero) else $error("Page zero forwarded as extended.");

    // The write page is one bit narrower, so a forwarded write never reaches the top half of pages.
    property p_write_page_narrow;
        extReq && extWrite |-> !extAddr[edw_pkg::EXT_ADDR_W-1];
    endproperty
    a_write_page_narrow: assert property (p_write_page_narrow) else $error("Write page wider than allowed.");

    property p_ram_pages;
        tgtRam |-> extAddr[24:15] != 10'h000 && extAddr[24:15] <= RAM_LAST_PAGE;
    endproperty
    a_ram_pages: assert property (p_ram_pages) else $error("RAM target outside the RAM pages.");

    property p_port_pages;
        tgtPort |-> extAddr[24:15] > RAM_LAST_PAGE && !extAddr[24];
    endproperty
    a_port_pages: assert property (p_port_pages) else $error("Port target on a RAM or program page.");

    property p_prog_read_only;
        tgtProg |-> !extWrite && extAddr[edw_pkg::EXT_ADDR_W-1];
    endproperty
    a_prog_read_only: assert property (p_prog_read_only) else $error("Program space target misused.");

    property p_write_load;
        writePageLoad |=> dataWritePageSelect == $past(writePageValue);
    endproperty
    a_write_load: assert property (p_write_load) else $error("Write page load not taken.");

    property p_read_hold;
        !readPageLoad |=> $stable(dataReadPageSelect);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("Read page changed without a load.");

    property p_write_hold;
        !writePageLoad |=> $stable(dataWritePageSelect);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("Write page changed without a load.");

    property p_forward_copy;
        accReq |=> fwdWdata == $past(accWdata) && extWrite == $past(accWrite);
    endproperty
    a_forward_copy: assert property (p_forward_copy) else $error("Write data or direction not forwarded.");
endmodule : edw_window

//--- verification/edw_core_model.sv
// Behavioural processor core whose access strobe stays high from issue until idle.
// Assumes the bench calls its tasks just after a falling edge of core_clk.
`timescale 1ns/1ps
module edw_core_model (
    output logic accReq, // Access strobe.
    output logic accWrite, // Write direction.
    output logic [15:0] accAddr, // Data address.
    output logic [15:0] accWdata // Write data.
);
    initial begin
        accReq = 1'b0;
        accWrite = 1'b0;
        accAddr = 16'h0000;
        accWdata = 16'h0000;
    end
    task issue(input logic w, input logic [15:0] a);
        accReq = 1'b1;
        accWrite = w;
        accAddr = a;
        accWdata = ~a;
    endtask : issue
    // Idle address and data lines flip so that a stale copy of them can never pass for fresh data.
    task idle();
        accReq = 1'b0;
        accAddr = ~accAddr;
        accWdata = ~accWdata;
    endtask : idle
endmodule : edw_core_model

//--- verification/test_extended_data_page_window.sv
// Self-checking bench for the extended data page window.
// Assumes the core model drives accesses; page selects come from the bench.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module test_extended_data_page_window;
    typedef struct packed {logic [9:0] rp; logic [8:0] wp; logic wr; logic [15:0] ad; logic [2:0] kind; logic [2:0] tgt;} edw_row_s;
    logic core_clk = 1'b0, rst_b = 1'b0, readPageLoad = 1'b0, writePageLoad = 1'b0;
    logic [9:0] readPageValue = 10'h000, rps;
    logic [8:0] writePageValue = 9'h000, wps;
    logic baseReq, extReq, extWrite, tgtRam, tgtPort, tgtProg, addrErrTrap, accReq, accWrite;
    logic [15:0] baseAddr, fwdWdata, accAddr, accWdata;
    logic [24:0] extAddr;
    int num_errors = 0, checks = 0, cycles = 0;
    // Kind is {base, ext, trap}; target is {ram, port, program space}; pages 1..2 are RAM here.
    edw_row_s rows [8] = '{'{10'h003, 9'h002, 1'b0, 16'h8004, 3'b010, 3'b010},
        '{10'h003, 9'h002, 1'b1, 16'hFFFE, 3'b010, 3'b100}, '{10'h200, 9'h001, 1'b0, 16'h8000, 3'b010, 3'b001},
        '{10'h001, 9'h1FF, 1'b1, 16'hC000, 3'b010, 3'b010}, '{10'h000, 9'h005, 1'b0, 16'h8002, 3'b001, 3'b000},
        '{10'h005, 9'h000, 1'b1, 16'h8002, 3'b001, 3'b000}, '{10'h000, 9'h000, 1'b0, 16'h0800, 3'b100, 3'b000},
        '{10'h000, 9'h000, 1'b1, 16'h7FFF, 3'b100, 3'b000}};
    always #4 core_clk = ~core_clk;
    edw_core_model i_core (.accReq(accReq), .accWrite(accWrite), .accAddr(accAddr), .accWdata(accWdata));
    edw_window #(.RAM_LAST_PAGE(10'h002)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .readPageLoad(readPageLoad), .readPageValue(readPageValue), .writePageLoad(writePageLoad),
        .writePageValue(writePageValue), .accReq(accReq), .accWrite(accWrite), .accAddr(accAddr),
        .accWdata(accWdata), .dataReadPageSelect(rps), .dataWritePageSelect(wps), .baseReq(baseReq),
        .baseAddr(baseAddr), .extReq(extReq), .extWrite(extWrite), .extAddr(extAddr), .fwdWdata(fwdWdata),
        .tgtRam(tgtRam), .tgtPort(tgtPort), .tgtProg(tgtProg), .addrErrTrap(addrErrTrap));
    task give_verdict();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task access(input edw_row_s r);
        logic [9:0] pg;
        pg = r.wr ? {1'b0, r.wp} : r.rp;
        @(negedge core_clk);
        `CHK({rps, wps}, {r.rp, r.wp})
        i_core.issue(r.wr, r.ad);
        @(negedge core_clk);
        i_core.idle();
        `CHK({baseReq, extReq, addrErrTrap}, r.kind)
        `CHK({tgtRam, tgtPort, tgtProg}, r.tgt)
        `CHK(r.kind[1] ? extAddr : {9'h000, baseAddr}, r.kind[1] ? {pg, r.ad[14:0]} : {9'h000, r.ad})
        `CHK({extWrite, fwdWdata}, {r.wr, ~r.ad})
    endtask : access
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(negedge core_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            {readPageLoad, writePageLoad, readPageValue, writePageValue} = {2'b11, rows[i].rp, rows[i].wp};
            @(negedge core_clk);
            {readPageLoad, writePageLoad} = 2'b00;
            access(rows[i]);
            $display("row %0d done", i);
        end
        // A load in the same cycle as an access must not affect that access.
        {readPageLoad, readPageValue} = {1'b1, 10'h004};
        i_core.issue(1'b0, 16'h9000);
        @(negedge core_clk);
        readPageLoad = 1'b0;
        `CHK({baseReq, extReq, addrErrTrap}, 3'b001)
        @(negedge core_clk);
        i_core.idle();
        `CHK({extReq, tgtPort, extAddr}, {2'b11, 10'h004, 15'h1000})
        $display("same-cycle load done");
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        `CHK({baseReq, extReq, addrErrTrap}, 3'b000)
        access(edw_row_s'{10'h001, 9'h001, 1'b0, 16'h8010, 3'b010, 3'b100});
        $display("reset test done");
        give_verdict();
    end
endmodule : test_extended_data_page_window
